// *** lai_top.sv ***
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lai_regs.svh"
// Operation
// - Polarity bit sets alert active level
// - Alert defaults active low after reset
// - Disable bit one disables alert output
// - Out-of-limit result activates alert
// - Release needs in-range result and a status read or write-one clear
// - Two status registers name the source
// - Alert pin is open drain
// - Two-wire mode makes alert an SMBus alert
// - Answer returns own address, LSB one
// - Lowest address wins, losers stay pending
// - Release after answer only once cleared
// - Address latched on second own-address frame
module lai_top import lai_pkg::*; #(
  parameter int NCH = `LAI_NCH,
  parameter logic [6:0] ADDR_LO = 7'h48,
  parameter logic [6:0] ADDR_HI = 7'h4a
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire lai_meas_t meas,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic addr_pin,
  input wire logic i2c_mode,
  output logic alert_o,
  output logic alert_oe_n,
  output logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic scl_s, sda_s, addr_s, i2c_s; // Synchronised pins
  logic [7:0] cfg; // Control configuration
  logic [NCH-1:0] stat_hi, stat_lo; // Sticky over/under status
  logic [NCH-1:0] mask_hi, mask_lo; // Alert masks
  logic [NCH-1:0] out_hi, out_lo; // Last result out of range
  logic [NCH-1:0] set_hi; // Over-limit events this cycle
  logic [9:0] lim_hi [NCH]; // Upper limits
  logic [9:0] lim_lo [NCH]; // Lower limits
  logic aw_full, w_full; // Write halves held
  logic [7:0] wr_addr; // Held write address
  logic [31:0] wr_data; // Held write data
  logic [3:0] wr_strb; // Held byte strobes
  logic wr_go; // Write performed this cycle
  logic ar_go; // Read taken this cycle
  logic [31:0] next_rdata; // Read mux
  logic next_rok; // Read address decoded
  logic next_wok; // Write address decoded
  logic rd_s1, rd_s2; // Status reads
  logic w1c_s1, w1c_s2; // Status writes
  logic any_set; // Unmasked status present
  logic respond_en; // May answer alert response
  logic [6:0] own_addr; // Current bus address
  logic addr_locked; // Address latched

  // Pin synchronisers
  lai_sync #(.W(4), .RST(`LAI_PIN_IDLE)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({scl_i, sda_i, addr_pin, i2c_mode}),
    .q({scl_s, sda_s, addr_s, i2c_s})
  );

  // Handshakes
  assign awready = ~aw_full & ~bvalid;
  assign wready = ~w_full & ~bvalid;
  assign arready = ~rvalid;
  assign wr_go = aw_full & w_full & ~bvalid;
  assign ar_go = arvalid & arready;
  assign rd_s1 = ar_go && araddr == `LAI_STAT1;
  assign rd_s2 = ar_go && araddr == `LAI_STAT2;
  assign w1c_s1 = wr_go && wr_addr == `LAI_STAT1 && wr_strb[0];
  assign w1c_s2 = wr_go && wr_addr == `LAI_STAT2 && wr_strb[0];

  // Write halves arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write address decode
  always_comb begin
    next_wok = 1'b0;
    case (wr_addr)
      `LAI_CFG, `LAI_STAT1, `LAI_STAT2, `LAI_MASK1, `LAI_MASK2, `LAI_ADDR: begin
        next_wok = 1'b1;
      end
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (wr_addr == 8'(`LAI_LIM0 + 4 * i)) begin
            next_wok = 1'b1;
          end
        end
      end
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `LAI_RESP_OK;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= next_wok ? `LAI_RESP_OK : `LAI_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration and masks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= `LAI_CFG_RST;
      mask_hi <= NCH'(`LAI_MASK_RST);
      mask_lo <= NCH'(`LAI_MASK_RST);
    end else if (wr_go && wr_strb[0]) begin
      if (wr_addr == `LAI_CFG) begin
        cfg <= wr_data[7:0];
      end
      if (wr_addr == `LAI_MASK1) begin
        mask_hi <= wr_data[NCH-1:0];
      end
      if (wr_addr == `LAI_MASK2) begin
        mask_lo <= wr_data[NCH-1:0];
      end
    end
  end

  // Per-channel limits, comparison and status
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam logic [7:0] LIM_OFS = 8'(`LAI_LIM0 + 4 * g);
    logic [9:0] lh, ll; // Limit pair
    logic oh, ol; // Condition of last result
    logic sh, sl; // Sticky status
    logic hit, hi_ex, lo_ex, clr_h, clr_l;
    assign hit = meas.valid && meas.chan == 3'(g);
    assign hi_ex = hit && meas.value > lh;
    assign lo_ex = hit && meas.value < ll;
    // Clear only once the last result is back in range
    assign clr_h = (rd_s1 || (w1c_s1 && wr_data[g])) && !oh;
    assign clr_l = (rd_s2 || (w1c_s2 && wr_data[g])) && !ol;
    assign lim_hi[g] = lh;
    assign lim_lo[g] = ll;
    assign out_hi[g] = oh;
    assign out_lo[g] = ol;
    assign stat_hi[g] = sh;
    assign stat_lo[g] = sl;
    assign set_hi[g] = hi_ex;
    // Limit registers
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        lh <= `LAI_LIM_HI_RST;
        ll <= `LAI_LIM_LO_RST;
      end else if (wr_go && wr_addr == LIM_OFS) begin
        if (&wr_strb[1:0]) begin
          ll <= wr_data[9:0];
        end
        if (&wr_strb[3:2]) begin
          lh <= wr_data[`LAI_LIM_HI_LSB +: 10];
        end
      end
    end
    // Condition of the latest conversion
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        oh <= 1'b0;
        ol <= 1'b0;
      end else if (hit) begin
        oh <= hi_ex;
        ol <= lo_ex;
      end
    end
    // Status: a new event wins over a clear
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sh <= 1'b0;
        sl <= 1'b0;
      end else begin
        sh <= hi_ex | (sh & ~clr_h);
        sl <= lo_ex | (sl & ~clr_l);
      end
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok = 1'b1;
    case (araddr)
      `LAI_CFG: next_rdata = {24'h00_0000, cfg};
      `LAI_STAT1: next_rdata = 32'(stat_hi);
      `LAI_STAT2: next_rdata = 32'(stat_lo);
      `LAI_MASK1: next_rdata = 32'(mask_hi);
      `LAI_MASK2: next_rdata = 32'(mask_lo);
      `LAI_ADDR: next_rdata = 32'({addr_locked, own_addr});
      default: begin
        next_rok = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (araddr == 8'(`LAI_LIM0 + 4 * i)) begin
            next_rok = 1'b1;
            next_rdata = {6'h00, lim_hi[i], 6'h00, lim_lo[i]};
          end
        end
      end
    endcase
  end

  // Read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `LAI_RESP_OK;
    end else if (ar_go) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rok ? `LAI_RESP_OK : `LAI_RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Alert source: any unmasked sticky status
  assign any_set = |((stat_hi & mask_hi) | (stat_lo & mask_lo));
  // Two-wire mode turns the alert into an SMBus alert
  assign respond_en = i2c_s & irq & ~cfg[`LAI_DIS_BIT];

  // Interrupt and open-drain alert pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      irq <= any_set;
      if (cfg[`LAI_DIS_BIT]) begin
        alert_oe_n <= 1'b1;
      end else if (cfg[`LAI_POL_BIT]) begin
        alert_oe_n <= any_set;
      end else begin
        alert_oe_n <= ~any_set;
      end
    end
  end
  // Open drain: only ever sinks
  assign alert_o = 1'b0;
  assign sda_o = 1'b0;

  // Alert response engine
  lai_ara #(.ADDR_LO(ADDR_LO), .ADDR_HI(ADDR_HI)) u_ara (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .addr_pin_s(addr_s),
    .respond_en(respond_en),
    .sda_oe_n(sda_oe_n),
    .own_addr(own_addr),
    .addr_locked(addr_locked),
    .ara_done()
  );

  alert_low_a: assert property ($stable(cfg) && !cfg[`LAI_DIS_BIT] && !cfg[`LAI_POL_BIT]
    |-> alert_oe_n == !irq) else $error("Active-low alert wrong");
  alert_high_a: assert property ($stable(cfg) && !cfg[`LAI_DIS_BIT] && cfg[`LAI_POL_BIT]
    |-> alert_oe_n == irq) else $error("Active-high alert wrong");
  pol_default_a: assert property (!$past(aresetn) |-> !cfg[`LAI_POL_BIT] && alert_oe_n)
    else $error("Reset polarity not active low");
  alert_dis_a: assert property ($stable(cfg) && cfg[`LAI_DIS_BIT] |-> alert_oe_n)
    else $error("Disabled alert driven");
  stat_set_a: assert property (set_hi[0] && mask_hi[0] |=> stat_hi[0] ##1 irq)
    else $error("Over-limit not flagged");
  stat_hold_a: assert property (stat_hi[0] && out_hi[0] |=> stat_hi[0])
    else $error("Status cleared while out of range");
  stat_clr_a: assert property ($fell(stat_lo[0]) |-> $past(rd_s2 || w1c_s2) && !out_lo[0])
    else $error("Status cleared without access");
  cov_irq: cover property ($rose(irq));
  cov_release: cover property ($fell(irq) ##[1:8] alert_oe_n);
  cov_lock: cover property ($rose(addr_locked));
endmodule

// *** lai_regs.svh ***
`ifndef LAI_REGS_SVH
`define LAI_REGS_SVH
// Register byte offsets
`define LAI_CFG 8'h00
`define LAI_STAT1 8'h04
`define LAI_STAT2 8'h08
`define LAI_MASK1 8'h0c
`define LAI_MASK2 8'h10
`define LAI_ADDR 8'h14
`define LAI_LIM0 8'h20
// Control configuration fields
`define LAI_POL_BIT 6
`define LAI_DIS_BIT 5
`define LAI_CFG_RST 8'h00
// Status, mask and limit layout
`define LAI_NCH 7
`define LAI_MASK_RST 7'h7f
`define LAI_LIM_HI_LSB 16
`define LAI_LIM_HI_RST 10'h3ff
`define LAI_LIM_LO_RST 10'h000
`define LAI_ADDR_LOCK_BIT 7
// Alert response address and bus answers
`define LAI_ARA 7'h0c
`define LAI_RESP_OK 2'b00
`define LAI_RESP_ERR 2'b10
// Alert response bit counts
`define LAI_BIT_LAST 4'h7
`define LAI_BIT_CNT 4'h8
// Pin idle levels, ordered {scl, sda, addr, mode}
`define LAI_PIN_IDLE 4'hc
`endif

// *** lai_pkg.sv ***
package lai_pkg;
  // One conversion result from the converter
  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [9:0] value;
  } lai_meas_t;
  // Alert response engine states, Gray along the path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_SEND = 3'b010,
    ST_MACK = 3'b110
  } lai_state_t;
endpackage

// *** lai_sync.sv ***
`timescale 1ns/1ps
// Two flip-flop synchroniser for pin levels
module lai_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0 // Level held in reset, the pins' idle level
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by q
  // Two stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Start at the idle level so no false edge follows reset
      meta <= RST;
      q <= RST;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** lai_ara.sv ***
`timescale 1ns/1ps
`include "lai_regs.svh"
// Alert response responder and bus address latch
module lai_ara import lai_pkg::*; #(
  parameter logic [6:0] ADDR_LO = 7'h48,
  parameter logic [6:0] ADDR_HI = 7'h4a
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic addr_pin_s,
  input wire logic respond_en,
  output logic sda_oe_n,
  output logic [6:0] own_addr,
  output logic addr_locked,
  output logic ara_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic scl_d, sda_d; // Previous samples
  lai_state_t state; // Engine state
  logic [3:0] cnt; // Bit counter
  logic [7:0] shreg; // Received bits
  logic [7:0] tx; // Outgoing byte
  logic ack_ph; // Ack slot entered
  logic drive; // Pull data low
  logic hits; // First own-address seen
  logic [6:0] latched; // Locked address
  logic [6:0] cand; // Address from pin
  logic [7:0] byte_in; // Byte with current bit
  logic scl_rise, scl_fall, start, stop;

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  assign cand = addr_pin_s ? ADDR_HI : ADDR_LO;
  assign byte_in = {shreg[6:0], sda_s};
  assign own_addr = addr_locked ? latched : cand;
  assign sda_oe_n = ~drive;

  // Edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ack_ph <= 1'b0;
      drive <= 1'b0;
    end else if (start) begin
      state <= ST_ADDR;
      cnt <= 4'h0;
      drive <= 1'b0;
    end else if (stop) begin
      state <= ST_IDLE;
      drive <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          drive <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shreg <= byte_in;
            cnt <= 4'(cnt + 4'h1);
            ack_ph <= 1'b0;
            if (cnt == `LAI_BIT_LAST) begin
              // Only the alert response read, and only while alerting
              if (byte_in == {`LAI_ARA, 1'b1} && respond_en) begin
                state <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_ph) begin
              drive <= 1'b1;
              ack_ph <= 1'b1;
              tx <= {own_addr, 1'b1};
            end else begin
              drive <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              cnt <= 4'h0;
              state <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise && !drive && !sda_s) begin
            // Lost arbitration: release, alert stays pending
            drive <= 1'b0;
            state <= ST_IDLE;
          end else if (scl_rise) begin
            cnt <= 4'(cnt + 4'h1);
          end else if (scl_fall) begin
            if (cnt == `LAI_BIT_CNT) begin
              drive <= 1'b0;
              state <= ST_MACK;
            end else begin
              drive <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          drive <= 1'b0;
        end
      endcase
    end
  end

  // Answer completed pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ara_done <= 1'b0;
    end else begin
      ara_done <= (state == ST_MACK) && scl_rise && !start && !stop;
    end
  end

  // Address latch on the eighth clock of the second own-address frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hits <= 1'b0;
      addr_locked <= 1'b0;
      latched <= 7'h00;
    end else if (!start && !stop && state == ST_ADDR && scl_rise && cnt == `LAI_BIT_LAST &&
                 byte_in[7:1] == cand && !addr_locked) begin
      if (hits) begin
        addr_locked <= 1'b1;
        latched <= cand;
      end else begin
        hits <= 1'b1;
      end
    end
  end

  ara_ack_a: assert property (!start && !stop && state == ST_ADDR && scl_rise && cnt == `LAI_BIT_LAST &&
    byte_in == {`LAI_ARA, 1'b1} && respond_en |=> state == ST_ACK) else $error("ARA not acked");
  ara_silent_a: assert property (!start && state == ST_ADDR && scl_rise && cnt == `LAI_BIT_LAST &&
    !respond_en |=> state == ST_IDLE && !drive) else $error("Answered while not alerting");
  arb_lost_a: assert property (!start && !stop && state == ST_SEND && scl_rise && !drive &&
    !sda_s |=> !drive && state == ST_IDLE) else $error("Kept driving after lost arbitration");
  addr_lock_a: assert property (addr_locked |=> addr_locked && $stable(latched))
    else $error("Locked address changed");
  cov_answer: cover property (ara_done);
  cov_lost: cover property (state == ST_SEND ##1 state == ST_IDLE);
endmodule

// *** lai_host.sv ***
`timescale 1ns/1ps
// Two-wire host that runs frames and alert reads; SCL stands high between frames
module lai_host (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // Both lines released while no frame runs
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // One bit slot: data changes mid-low, sampled on the rising edge;
  // non-blocking updates so a change on a clock edge never races the synchroniser
  task automatic slot(input logic v, output logic s);
    #12 sda_drv <= v;
    #12 scl <= 1'h1;
    s = sda;
    #24 scl <= 1'h0;
  endtask
  // Address byte and acknowledge, one data byte on a read, then no-ack and stop;
  // a rival device with byte rv (8'hff for none) sinks the wire where its bits are 0
  task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] rv, output logic ack,
                       output logic [7:0] data);
    logic [7:0] b;
    logic s;
    b = {a, rw};
    data = 8'h00;
    sda_drv <= 1'h0; // Start
    #24 scl <= 1'h0;
    for (int i = 7; i >= 0; i--) begin
      slot(b[i], s);
    end
    slot(rv == 8'hff, s); // Rival acknowledges as well
    ack = ~s;
    if (ack && rw) begin
      for (int i = 7; i >= 0; i--) begin
        slot(rv[i], data[i]);
      end
      slot(1'h1, s); // No-ack ends the read
    end
    #12 sda_drv <= 1'h0; // Stop
    #12 scl <= 1'h1;
    #12 sda_drv <= 1'h1;
    #24;
  endtask
  // Alert response read, never aimed at a device's own address
  task automatic ara(input logic [7:0] rv, output logic ack, output logic [7:0] data);
    frame(7'h0c, 1'h1, rv, ack, data);
  endtask
endmodule

// *** limit_alert_interrupt_tb.sv ***
`timescale 1ns/1ps
`include "lai_regs.svh"
// Register-level bench with a two-wire host on the data wire
module limit_alert_interrupt_tb import lai_pkg::*; ();
  logic aclk, aresetn; // Clock and reset
  logic [7:0] awaddr, araddr; // Bus addresses
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d; // Bus data and last read word
  logic [3:0] wstrb; // Byte strobes
  logic [1:0] bresp, rresp, r; // Responses and last read answer
  lai_meas_t meas; // Conversion result
  logic scl, host_sda, sda, sda_o, sda_oe_n; // Data wire parties
  logic addr_pin, i2c_mode, alert_o, alert_oe_n, irq, alert_wire;
  logic ack; // Alert read acknowledged
  logic [7:0] data; // Byte the host read
  int n_mismatch, checked; // Counters
  // Pulled-up wires fall only where some party sinks
  assign sda = host_sda & (sda_oe_n | sda_o);
  assign alert_wire = alert_oe_n | alert_o;
  lai_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .meas(meas), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .i2c_mode(i2c_mode), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .irq(irq));
  lai_host i_host (.scl(scl), .sda_drv(host_sda), .sda(sda));
  // 250 MHz clock
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bus write: both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] br;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (tb !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, br}, {30'h0, er});
  endtask
  // Bus read into d and r
  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (tr !== 1'h1);
    rready <= 1'h0;
  endtask
  // Read expecting an OKAY answer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk({30'h0, r}, 32'h0);
    chk(d, e);
  endtask
  // Irq and alert wire once settled
  task automatic pins(input logic ei, input logic ew);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk({30'h0, irq, alert_wire}, {30'h0, ei, ew});
  endtask
  // One conversion pulse
  task automatic meas_go(input logic [2:0] c, input logic [9:0] v);
    @(posedge aclk);
    meas <= '{1'h1, c, v};
    @(posedge aclk);
    meas <= '0;
  endtask
  // Pins may only sink, never drive high
  always @(negedge aclk) begin
    if (aresetn === 1'h1) chk({30'h0, alert_o, sda_o}, 32'h0);
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    aresetn = 1'h0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    meas = '0;
    addr_pin = 1'h0;
    i2c_mode = 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`LAI_CFG, 32'h0);
    rd_chk(`LAI_MASK1, 32'h7f);
    rd_chk(`LAI_MASK2, 32'h7f);
    rd_chk(`LAI_LIM0, 32'h03ff0000);
    rd_chk(`LAI_STAT1, 32'h0);
    pins(1'h0, 1'h1);
    axi_rd(8'h18);
    chk({30'h0, r}, 32'h2);
    axi_wr(8'h18, 32'hffffffff, 2'h2);
    rd_chk(`LAI_CFG, 32'h0);
    $display("test reset finished");
    for (int c = 0; c < 7; c++) axi_wr(`LAI_LIM0 + 8'(4 * c), 32'h01000010, 2'h0);
    for (int c = 0; c < 7; c++) meas_go(3'(c), 10'h200);
    rd_chk(`LAI_STAT1, 32'h7f);
    pins(1'h1, 1'h0);
    for (int c = 0; c < 7; c++) meas_go(3'(c), 10'h005);
    rd_chk(`LAI_STAT2, 32'h7f);
    for (int c = 0; c < 7; c++) meas_go(3'(c), c[0] ? 10'h100 : 10'h010);
    pins(1'h1, 1'h0);
    rd_chk(`LAI_STAT1, 32'h7f);
    pins(1'h1, 1'h0);
    rd_chk(`LAI_STAT2, 32'h7f);
    pins(1'h0, 1'h1);
    rd_chk(`LAI_STAT1, 32'h0);
    $display("test limits finished");
    meas_go(3'h0, 10'h200);
    axi_wr(`LAI_MASK1, 32'h0, 2'h0);
    pins(1'h0, 1'h1);
    axi_wr(`LAI_MASK1, 32'h7f, 2'h0);
    pins(1'h1, 1'h0);
    axi_wr(`LAI_STAT1, 32'h1, 2'h0);
    rd_chk(`LAI_STAT1, 32'h1);
    meas_go(3'h0, 10'h080);
    axi_wr(`LAI_STAT1, 32'h1, 2'h0);
    pins(1'h0, 1'h1);
    $display("test mask finished");
    i2c_mode <= 1'h1;
    i_host.frame(7'h48, 1'h0, 8'hff, ack, data);
    rd_chk(`LAI_ADDR, 32'h48);
    i_host.frame(7'h48, 1'h0, 8'hff, ack, data);
    rd_chk(`LAI_ADDR, 32'hc8);
    addr_pin <= 1'h1;
    repeat (4) @(posedge aclk); // New strap level reaches the address logic
    rd_chk(`LAI_ADDR, 32'hc8);
    $display("test address finished");
    meas_go(3'h0, 10'h200);
    axi_wr(`LAI_CFG, 32'h0, 2'h0);
    pins(1'h1, 1'h0);
    i_host.ara(8'hff, ack, data);
    chk({31'h0, ack}, 32'h1);
    chk({24'h0, data}, 32'h91);
    pins(1'h1, 1'h0);
    i_host.ara(8'h21, ack, data);
    chk({24'h0, data}, 32'h21);
    pins(1'h1, 1'h0);
    i_host.ara(8'hff, ack, data);
    chk({24'h0, data}, 32'h91);
    @(posedge aclk);
    i2c_mode <= 1'h0;
    i_host.ara(8'hff, ack, data);
    chk({31'h0, ack}, 32'h0);
    @(posedge aclk);
    i2c_mode <= 1'h1;
    axi_wr(`LAI_CFG, 32'h20, 2'h0);
    pins(1'h1, 1'h1);
    i_host.ara(8'hff, ack, data);
    chk({31'h0, ack}, 32'h0);
    $display("test alert response finished");
    axi_wr(`LAI_CFG, 32'h40, 2'h0);
    pins(1'h1, 1'h1);
    meas_go(3'h0, 10'h080);
    rd_chk(`LAI_STAT1, 32'h1);
    pins(1'h0, 1'h0);
    axi_wr(`LAI_CFG, 32'h0, 2'h0);
    pins(1'h0, 1'h1);
    $display("test polarity finished");
    stop_test();
  end
endmodule
